// ===== spi_host_pkg.sv
`default_nettype none

package spi_host_pkg;

  // command byte layout
  localparam logic [7:0] CMD_REG_READ = 8'h80;
  localparam logic [7:0] CMD_REG_WRITE = 8'hC0;
  localparam logic [7:0] CMD_FB_READ = 8'h20;
  localparam logic [7:0] CMD_FB_WRITE = 8'h60;
  localparam logic [7:0] CMD_SRAM_READ = 8'h00;
  localparam logic [7:0] CMD_SRAM_WRITE = 8'h40;
  localparam logic [7:0] REG_ADDR_MASK = 8'h3F;

  // device register map
  localparam logic [5:0] PHY_MISC_CONTROL_ADDR = 6'h04;
  localparam int STATUS_SEL_LSB = 2;
  localparam int STATUS_SEL_MSB = 3;
  localparam logic [7:0] STATUS_PREFIX_RESET = 8'h00;

  // frame and sram limits
  localparam logic [7:0] FRAME_LEN_MAX = 8'h7F;
  localparam int FB_READ_OVERHEAD = 5;
  localparam int FB_WRITE_OVERHEAD = 2;
  localparam logic [7:0] SRAM_FB_LAST = 8'h7F;
  localparam logic [7:0] SRAM_AES_FIRST = 8'h82;
  localparam logic [7:0] SRAM_AES_LAST = 8'h94;
  localparam int BUF_DEPTH = 128;

  // serial clock timing
  localparam int CORE_CLK_MHZ_X10 = 1000;
  localparam int SCLK_MAX_SYNC_MHZ_X10 = 80;
  localparam int SCLK_MAX_ASYNC_MHZ_X10 = 75;
  localparam int SCLK_HALF_SYNC = (CORE_CLK_MHZ_X10 + 2 * SCLK_MAX_SYNC_MHZ_X10 - 1) / (2 * SCLK_MAX_SYNC_MHZ_X10);
  localparam int SCLK_HALF_ASYNC = (CORE_CLK_MHZ_X10 + 2 * SCLK_MAX_ASYNC_MHZ_X10 - 1) / (2 * SCLK_MAX_ASYNC_MHZ_X10);
  localparam logic [3:0] SCLK_HALF_SYNC_CNT = 4'(SCLK_HALF_SYNC);
  localparam logic [3:0] SCLK_HALF_ASYNC_CNT = 4'(SCLK_HALF_ASYNC);
  localparam logic [2:0] BITS_PER_BYTE_M1 = 3'h7;

  // software register offsets
  localparam logic [3:0] SW_CTRL = 4'h0;
  localparam logic [3:0] SW_CMD = 4'h1;
  localparam logic [3:0] SW_ADDR = 4'h2;
  localparam logic [3:0] SW_LEN = 4'h3;
  localparam logic [3:0] SW_STATUS = 4'h4;
  localparam logic [3:0] SW_PREFIX = 4'h5;
  localparam logic [3:0] SW_BUF = 4'h6;
  localparam logic [3:0] SW_BUF_PTR = 4'h7;
  localparam logic [3:0] SW_RDATA = 4'h8;

  // control register bits
  localparam int CTRL_GO = 0;
  localparam int CTRL_SYNC = 1;

  typedef enum logic [2:0] {
    ACC_REG_READ, ACC_REG_WRITE, ACC_FB_READ, ACC_FB_WRITE, ACC_SRAM_READ, ACC_SRAM_WRITE
  } access_t;

  // one software order
  typedef struct packed {
    access_t access;
    logic [7:0] addr;
    logic [7:0] len;
    logic sync_mode;
  } order_t;

  // pins towards the device
  typedef struct packed {
    logic sel_n;
    logic sclk;
    logic mosi;
  } spi_pins_t;

endpackage : spi_host_pkg

`default_nettype wire

// ===== spi_byte_shifter.sv
`timescale 1ns/100ps
`default_nettype none

module spi_byte_shifter (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic [7:0] i_tx_byte,
  input wire logic [3:0] i_half_cnt,
  input wire logic i_miso,
  output logic o_sclk,
  output logic o_mosi,
  output logic o_done,
  output logic [7:0] o_rx_byte
);
  import spi_host_pkg::*;

  logic busy_reg;
  logic [3:0] tick_reg;
  logic [2:0] bit_reg;
  logic [7:0] tx_reg;
  logic [7:0] rx_reg;
  logic miso_s1_reg, miso_s2_reg, miso_s3_reg;
  logic miso_filt_reg;
  logic half_end;

  assign half_end = busy_reg && (tick_reg == i_half_cnt - 4'h1);

  // three-stage capture of the device data line; a change counts once stages two and three agree
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      miso_s1_reg <= 1'b0;
      miso_s2_reg <= 1'b0;
      miso_s3_reg <= 1'b0;
      miso_filt_reg <= 1'b0;
    end else begin
      miso_s1_reg <= i_miso;
      miso_s2_reg <= miso_s1_reg;
      miso_s3_reg <= miso_s2_reg;
      if (miso_s2_reg == miso_s3_reg) begin
        miso_filt_reg <= miso_s3_reg;
      end
    end
  end

  // half-period timer
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || !busy_reg || half_end) begin
      tick_reg <= 4'h0;
    end else begin
      tick_reg <= tick_reg + 4'h1;
    end
  end

  // mode 0 shifting, msb first, eight clocks per byte
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      busy_reg <= 1'b0;
      o_sclk <= 1'b0;
      o_mosi <= 1'b0;
      bit_reg <= 3'h0;
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
      o_done <= 1'b0;
      o_rx_byte <= 8'h00;
    end else begin
      o_done <= 1'b0;
      if (i_start && !busy_reg) begin
        busy_reg <= 1'b1;
        bit_reg <= BITS_PER_BYTE_M1;
        tx_reg <= {i_tx_byte[6:0], 1'b0};
        o_mosi <= i_tx_byte[7];
      end else if (half_end && !o_sclk) begin
        o_sclk <= 1'b1;
        rx_reg <= {rx_reg[6:0], miso_filt_reg};
      end else if (half_end) begin
        o_sclk <= 1'b0;
        if (bit_reg == 3'h0) begin
          busy_reg <= 1'b0;
          o_done <= 1'b1;
          o_rx_byte <= rx_reg;
        end else begin
          bit_reg <= bit_reg - 3'h1;
          o_mosi <= tx_reg[7];
          tx_reg <= {tx_reg[6:0], 1'b0};
        end
      end
    end
  end

endmodule : spi_byte_shifter

`default_nettype wire

// ===== spi_host_ctrl.sv
// What this block does
// - sclk stays at or under 8 MHz when synchronous to the device clock.
// - sclk stays at or under 7.5 MHz in asynchronous mode.
// - select low starts a transfer; eight clocks per byte, full duplex.
// - bytes go msb first; select returns high to end a transaction.
// - no device pull-up, so the line needs an outside defined level.
// - don't-care bytes sent as valid levels; returned don't-cares ignored.
// - register access is two bytes, then select goes high.
// - frame write sends the length second, then the payload.
// - length at most 127; read 5+len, write 2+len bytes; only frame writes are checked against 127, a frame read length is not.
// - sram read is 000, write 010; second byte is start address.
// - sram 0x00-0x7F is frame buffer, 0x82-0x94 cipher; stay in range; refused only if the start is 0x80-0x81 or the end passes 0x94.
//
// Our own choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none

module spi_host_ctrl (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output spi_host_pkg::spi_pins_t o_spi,
  input wire logic i_miso,
  output logic o_busy
);
  import spi_host_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // software registers

  typedef enum {
    ST_IDLE, ST_SEL, ST_SHIFT, ST_WAIT, ST_DESEL
  } state_t;

  state_t state_reg;
  order_t order_reg;
  logic sync_reg;
  logic error_reg;
  logic done_reg;
  logic [7:0] prefix_reg;
  logic [7:0] rdata_reg;
  logic [7:0] buf_mem [BUF_DEPTH];
  logic [6:0] sw_ptr_reg;
  logic [6:0] link_ptr_reg;
  logic [7:0] byte_idx_reg;
  logic [7:0] total_reg;
  logic [7:0] tx_byte;
  logic [7:0] rx_byte;
  logic shift_start, shift_done, sclk, mosi;
  logic go;
  logic bad_order;
  logic [8:0] total_next;
  logic is_read;
  logic [7:0] header_len;

  assign go = i_wr && (i_addr == SW_CTRL) && i_wdata[CTRL_GO] && (state_reg == ST_IDLE);

  // order checks: length limit and sram range
  always_comb begin
    bad_order = 1'b0;
    if ((order_reg.access == ACC_FB_WRITE) && (order_reg.len > FRAME_LEN_MAX)) begin
      bad_order = 1'b1;
    end
    if ((order_reg.access == ACC_SRAM_READ) || (order_reg.access == ACC_SRAM_WRITE)) begin
      if ((order_reg.addr > SRAM_FB_LAST) && (order_reg.addr < SRAM_AES_FIRST)) begin
        bad_order = 1'b1;
      end
      if ({1'b0, order_reg.addr} + {1'b0, order_reg.len} > {1'b0, SRAM_AES_LAST} + 9'h001) begin
        bad_order = 1'b1;
      end
    end
  end

  // transaction length in bytes
  always_comb begin
    unique case (order_reg.access)
      ACC_REG_READ, ACC_REG_WRITE: total_next = 9'd2;
      ACC_FB_READ: total_next = 9'(FB_READ_OVERHEAD) + {1'b0, order_reg.len};
      ACC_FB_WRITE: total_next = 9'(FB_WRITE_OVERHEAD) + {1'b0, order_reg.len};
      ACC_SRAM_READ, ACC_SRAM_WRITE: total_next = 9'd2 + {1'b0, order_reg.len};
      default: total_next = 9'd2; // unused command codes
    endcase
  end

  // order fields written by software
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      order_reg <= '{access: ACC_REG_READ, addr: 8'h00, len: 8'h00, sync_mode: 1'b0};
      sync_reg <= 1'b0;
    end else if (i_wr && (state_reg == ST_IDLE)) begin
      unique case (i_addr)
        SW_CMD: order_reg.access <= access_t'(i_wdata[2:0]);
        SW_ADDR: order_reg.addr <= i_wdata;
        SW_LEN: order_reg.len <= i_wdata;
        SW_CTRL: sync_reg <= i_wdata[CTRL_SYNC];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // buffer shared by software and link

  always_ff @(posedge i_core_clk) begin
    if (i_wr && (i_addr == SW_BUF) && (state_reg == ST_IDLE)) begin
      buf_mem[sw_ptr_reg] <= i_wdata;
    end else if (shift_done && (byte_idx_reg >= header_len) && is_read) begin
      buf_mem[link_ptr_reg] <= rx_byte;
    end
  end

  // software pointer, auto-increment on buffer access
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      sw_ptr_reg <= 7'h00;
    end else if (i_wr && (i_addr == SW_BUF_PTR)) begin
      sw_ptr_reg <= i_wdata[6:0];
    end else if ((i_wr || i_rd) && (i_addr == SW_BUF)) begin
      sw_ptr_reg <= sw_ptr_reg + 7'h01;
    end
  end

  // read data one cycle after strobe
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      rdata_reg <= 8'h00;
    end else if (i_rd) begin
      unique case (i_addr)
        SW_CTRL: rdata_reg <= {6'h00, sync_reg, 1'b0};
        SW_CMD: rdata_reg <= {5'h00, order_reg.access};
        SW_ADDR: rdata_reg <= order_reg.addr;
        SW_LEN: rdata_reg <= order_reg.len;
        SW_STATUS: rdata_reg <= {5'h00, error_reg, done_reg, o_busy};
        SW_PREFIX: rdata_reg <= prefix_reg;
        SW_BUF: rdata_reg <= buf_mem[sw_ptr_reg];
        SW_BUF_PTR: rdata_reg <= {1'b0, sw_ptr_reg};
        default: rdata_reg <= 8'h00;
      endcase
    end
  end
  assign o_rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // link sequencer

  assign is_read = (order_reg.access == ACC_REG_READ) || (order_reg.access == ACC_FB_READ)
    || (order_reg.access == ACC_SRAM_READ);
  assign header_len = ((order_reg.access == ACC_SRAM_READ) || (order_reg.access == ACC_SRAM_WRITE)) ? 8'h02 : 8'h01;

  // byte to send: command, address, data or filler
  always_comb begin
    tx_byte = 8'h00;
    if (byte_idx_reg == 8'h00) begin
      unique case (order_reg.access)
        ACC_REG_READ: tx_byte = CMD_REG_READ | (order_reg.addr & REG_ADDR_MASK);
        ACC_REG_WRITE: tx_byte = CMD_REG_WRITE | (order_reg.addr & REG_ADDR_MASK);
        ACC_FB_READ: tx_byte = CMD_FB_READ;
        ACC_FB_WRITE: tx_byte = CMD_FB_WRITE;
        ACC_SRAM_READ: tx_byte = CMD_SRAM_READ;
        ACC_SRAM_WRITE: tx_byte = CMD_SRAM_WRITE;
      endcase
    end else if ((byte_idx_reg == 8'h01) && (header_len == 8'h02)) begin
      tx_byte = order_reg.addr;
    end else if ((byte_idx_reg == 8'h01) && (order_reg.access == ACC_FB_WRITE)) begin
      tx_byte = order_reg.len;
    end else if (!is_read) begin
      tx_byte = buf_mem[link_ptr_reg];
    end
  end

  // state and counters
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state_reg <= ST_IDLE;
      byte_idx_reg <= 8'h00;
      total_reg <= 8'h00;
      link_ptr_reg <= 7'h00;
      o_spi <= '{sel_n: 1'b1, sclk: 1'b0, mosi: 1'b0};
      done_reg <= 1'b0;
      error_reg <= 1'b0;
      prefix_reg <= STATUS_PREFIX_RESET;
    end else begin
      o_spi.sclk <= sclk;
      o_spi.mosi <= mosi;
      if (i_rd && (i_addr == SW_STATUS)) begin
        done_reg <= 1'b0;
        error_reg <= 1'b0;
      end
      unique case (state_reg)
        ST_IDLE: begin
          if (go && bad_order) begin
            error_reg <= 1'b1;
          end else if (go) begin
            state_reg <= ST_SEL;
            byte_idx_reg <= 8'h00;
            link_ptr_reg <= 7'h00;
            total_reg <= total_next[7:0];
            o_spi.sel_n <= 1'b0;
          end
        end
        ST_SEL: state_reg <= ST_SHIFT;
        ST_SHIFT: state_reg <= ST_WAIT;
        ST_WAIT: begin
          if (shift_done) begin
            if (byte_idx_reg == 8'h00) begin
              prefix_reg <= rx_byte;
            end
            // the length byte of a frame write comes from the order, not the buffer
            if ((byte_idx_reg >= header_len)
                && !((order_reg.access == ACC_FB_WRITE) && (byte_idx_reg == 8'h01))) begin
              link_ptr_reg <= link_ptr_reg + 7'h01;
            end
            if (byte_idx_reg == total_reg - 8'h01) begin
              state_reg <= ST_DESEL;
            end else begin
              state_reg <= ST_SHIFT;
            end
            byte_idx_reg <= byte_idx_reg + 8'h01;
          end
        end
        ST_DESEL: begin
          o_spi.sel_n <= 1'b1;
          done_reg <= 1'b1;
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  assign shift_start = (state_reg == ST_SHIFT);
  assign o_busy = (state_reg != ST_IDLE);

  // byte engine; half period picks the mode limit
  spi_byte_shifter u_shift (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_start(shift_start),
    .i_tx_byte(tx_byte),
    .i_half_cnt(sync_reg ? SCLK_HALF_SYNC_CNT : SCLK_HALF_ASYNC_CNT),
    .i_miso(i_miso),
    .o_sclk(sclk),
    .o_mosi(mosi),
    .o_done(shift_done),
    .o_rx_byte(rx_byte)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic [3:0] hi_cnt_reg;
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || !o_spi.sclk) begin
      hi_cnt_reg <= 4'h0;
    end else if (hi_cnt_reg != 4'hF) begin
      hi_cnt_reg <= hi_cnt_reg + 4'h1;
    end
  end

  a_sclk_rate: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $fell(o_spi.sclk) |-> $past(hi_cnt_reg) >= SCLK_HALF_ASYNC_CNT - 4'h1 - 4'h1)
    else $error("serial clock high phase too short");
  a_sclk_idle: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_spi.sel_n |-> !o_spi.sclk)
    else $error("serial clock toggles while deselected");
  a_sel_release: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (state_reg == ST_DESEL) |=> o_spi.sel_n && done_reg)
    else $error("select not released at end");
  a_sel_low_busy: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (state_reg == ST_SHIFT) |-> !o_spi.sel_n)
    else $error("shifting with select high");
  a_mosi_stable: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $rose(o_spi.sclk) |=> $stable(o_spi.mosi))
    else $error("mosi moved after rising sclk");
  a_reg_two: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    ($rose(o_busy) && (order_reg.access == ACC_REG_WRITE)) |-> total_reg == 8'h02)
    else $error("register access not two bytes");
  a_cmd_regbit: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (shift_start && byte_idx_reg == 8'h00 && order_reg.access == ACC_REG_READ) |-> tx_byte[7:6] == 2'b10)
    else $error("register read command wrong");
  a_fb_len: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (o_busy && order_reg.access == ACC_FB_WRITE) |-> order_reg.len <= FRAME_LEN_MAX)
    else $error("frame length over limit");

  // select stays low from the first byte to the release
  a_sel_held: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    ((state_reg == ST_SHIFT) || (state_reg == ST_WAIT) || (state_reg == ST_DESEL)) |-> !o_spi.sel_n)
    else $error("select released inside a transaction");

  // every byte of the order went out before release
  a_byte_total: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (state_reg == ST_DESEL) |-> byte_idx_reg == total_reg)
    else $error("byte count wrong at release");

  // frame write carries its length as the second byte
  a_fb_len_byte: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (shift_start && byte_idx_reg == 8'h01 && order_reg.access == ACC_FB_WRITE) |-> tx_byte == order_reg.len)
    else $error("frame length byte wrong");

  // sram write carries its start address as the second byte
  a_sram_addr: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (shift_start && byte_idx_reg == 8'h01 && order_reg.access == ACC_SRAM_WRITE) |-> tx_byte == order_reg.addr)
    else $error("sram address byte wrong");

  // a refused order raises error and never selects the device
  a_refuse_quiet: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (go && bad_order) |=> (state_reg == ST_IDLE) && error_reg && o_spi.sel_n)
    else $error("refused order started traffic");

  // command byte of a frame read has the frame pattern on top
  a_fb_cmd: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (shift_start && byte_idx_reg == 8'h00 && order_reg.access == ACC_FB_READ) |-> tx_byte[7:5] == 3'h1)
    else $error("frame read command wrong");

  // filler bytes of a read are driven low, not left floating
  a_read_fill: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (shift_start && byte_idx_reg >= header_len && is_read) |-> tx_byte == 8'h00)
    else $error("read filler byte not driven low");

  // serial clock is low whenever a byte starts
  a_sclk_start: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    shift_start |-> !sclk)
    else $error("byte started with sclk high");


  c_reg_read: cover property (@(posedge i_core_clk) (state_reg == ST_DESEL) && (order_reg.access == ACC_REG_READ));
  c_fb_write: cover property (@(posedge i_core_clk) (state_reg == ST_DESEL) && (order_reg.access == ACC_FB_WRITE));
  c_sram_read: cover property (@(posedge i_core_clk) (state_reg == ST_DESEL) && (order_reg.access == ACC_SRAM_READ));
  c_refused: cover property (@(posedge i_core_clk) go && bad_order);
  c_sync_run: cover property (@(posedge i_core_clk) (state_reg == ST_DESEL) && sync_reg);

endmodule : spi_host_ctrl

`default_nettype wire

// ===== spi_dev_model.sv
`timescale 1ns/100ps
`default_nettype none

module spi_dev_model #(
  parameter logic [7:0] CTRL_RESET = 8'h20
) (
  input wire logic i_sel_n,
  input wire logic i_sclk,
  input wire logic i_mosi,
  output logic o_miso
);
  logic [7:0] regs [0:63];
  logic [7:0] mem [0:255];
  logic [7:0] rx, tx, tx_next, cmd, ptr, b;
  int bitn;
  int nbyte;

  ////////////////////////////////////////////////////////////
  // register file and buffer start cleared, except register 4 which starts at CTRL_RESET
  initial begin
    foreach (regs[i]) regs[i] = 8'h00;
    foreach (mem[i]) mem[i] = 8'h00;
    regs[4] = CTRL_RESET;
    o_miso = 1'b1;
    bitn = 0;
    nbyte = 0;
    cmd = 8'h00;
    ptr = 8'h00;
    rx = 8'h00;
  end

  // select low opens a transaction with the prefix byte
  always @(negedge i_sel_n) begin
    bitn = 0;
    nbyte = 0;
    tx = (regs[4][3:2] == 2'h0) ? 8'h00 : {6'h00, regs[4][3:2]};
    o_miso = tx[7];
  end

  // released line has no pull-up: show the inverse of the last bit
  always @(posedge i_sel_n) o_miso = ~o_miso;

  // sample on rising clock, msb first, decode each whole byte
  always @(posedge i_sclk) begin
    if (!i_sel_n) begin
      b = {rx[6:0], i_mosi};
      rx = b;
      bitn = bitn + 1;
      if (bitn == 8) begin
        if (nbyte == 0) cmd = b;
        else if (cmd[7:6] == 2'b11 && nbyte == 1) regs[cmd[5:0]] = b;
        else if (cmd[7:5] == 3'b011 && nbyte == 1) begin
          mem[0] = b;
          ptr = 8'h01;
        end
        else if (!cmd[7] && !cmd[5] && nbyte == 1) ptr = b;
        else if (cmd[7:6] == 2'b01 && nbyte > 1) begin
          mem[ptr] = b;
          ptr = ptr + 8'h01;
        end
        else if (cmd[7:5] == 3'b000 && nbyte > 1) ptr = ptr + 8'h01;
        nbyte = nbyte + 1;
        if (cmd[7:6] == 2'b10 && nbyte == 1) tx_next = regs[cmd[5:0]];
        else if (cmd[7:5] == 3'b001) tx_next = mem[nbyte - 1];
        else if (cmd[7:5] == 3'b000 && nbyte > 1) tx_next = mem[ptr];
        else tx_next = 8'hA5;
      end
    end
  end

  // change the output on the falling clock
  always @(negedge i_sclk) begin
    if (!i_sel_n) begin
      if (bitn == 8) begin
        bitn = 0;
        tx = tx_next;
      end else begin
        tx = {tx[6:0], 1'b0};
      end
      o_miso = tx[7];
    end
  end
endmodule : spi_dev_model

`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
    end \
  end

module tb_top;
  import spi_host_pkg::*;
  logic i_core_clk, i_rst_n, i_wr, i_rd, i_miso, o_busy;
  logic [3:0] i_addr;
  logic [7:0] i_wdata, o_rdata;
  spi_pins_t o_spi;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  int last_n = 0;
  time t_rise = 0;

  spi_host_ctrl u_dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_spi(o_spi), .i_miso(i_miso), .o_busy(o_busy));
  spi_dev_model u_dev (.i_sel_n(o_spi.sel_n), .i_sclk(o_spi.sclk), .i_mosi(o_spi.mosi), .o_miso(i_miso));

  ////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  always @(posedge i_core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_mismatch++;
      close_out();
    end
  end

  // link watch: clock rate, idle level, bytes per transaction
  always @(posedge o_spi.sclk) begin
    if (t_rise != 0) `CHK("sclk_period", 1'b1, ($time - t_rise) >= 134)
    t_rise = $time;
  end
  always @(negedge o_spi.sel_n) `CHK("sclk_idle", 1'b0, o_spi.sclk)
  always @(posedge o_spi.sel_n) last_n = u_dev.nbyte;

  ////////////////////////////////////////////////////////////
  // register port access
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    @(posedge i_core_clk);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string nm);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1;
    `CHK(nm, exp, o_rdata)
    @(posedge i_core_clk);
  endtask : rd

  task automatic load(input logic [7:0] q[$]);
    wr(SW_BUF_PTR, 8'h00);
    foreach (q[i]) wr(SW_BUF, q[i]);
  endtask : load

  task automatic expect_buf(input logic [7:0] q[$]);
    wr(SW_BUF_PTR, 8'h00);
    foreach (q[i]) rd(SW_BUF, q[i], "buf");
  endtask : expect_buf

  // one order: program, start, wait for idle, check status and byte count
  task automatic run(input access_t acc, input logic [7:0] a, input logic [7:0] n, input logic s,
                     input logic [7:0] st, input int nb);
    int w;
    last_n = 0;
    wr(SW_CMD, 8'(acc));
    wr(SW_ADDR, a);
    wr(SW_LEN, n);
    wr(SW_CTRL, {6'h00, s, 1'b1});
    w = 0;
    while (o_busy !== 1'b0 && w < 20000) begin
      @(posedge i_core_clk);
      w++;
    end
    `CHK("finished", 1'b0, o_busy)
    rd(SW_STATUS, st, "status");
    `CHK("bytes", nb, last_n)
  endtask : run

  task close_out;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    i_rst_n = 1'b0;
    i_addr = 4'h0;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    repeat (12) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    @(posedge i_core_clk);
    rd(SW_STATUS, 8'h00, "status_reset");
    rd(4'hF, 8'h00, "unmapped");
    // register access at address 0x04 and at the top end of the address field
    run(ACC_REG_READ, 8'h04, 8'h00, 1'b0, 8'h02, 2);
    expect_buf('{8'h20});
    rd(SW_PREFIX, 8'h00, "prefix");
    rd(SW_STATUS, 8'h00, "status_clr");
    load('{8'h3C});
    run(ACC_REG_WRITE, 8'h3F, 8'h00, 1'b1, 8'h02, 2);
    run(ACC_REG_READ, 8'h3F, 8'h00, 1'b0, 8'h02, 2);
    expect_buf('{8'h3C});
    // sram up to the buffer's last byte, then read back from the middle
    load('{8'hA1, 8'hB2, 8'hC3, 8'hD4});
    run(ACC_SRAM_WRITE, 8'h7C, 8'h04, 1'b0, 8'h02, 6);
    run(ACC_SRAM_READ, 8'h7D, 8'h03, 1'b1, 8'h02, 5);
    expect_buf('{8'hB2, 8'hC3, 8'hD4});
    run(ACC_SRAM_WRITE, 8'h92, 8'h03, 1'b0, 8'h02, 5);
    run(ACC_SRAM_WRITE, 8'h80, 8'h01, 1'b0, 8'h04, 0);
    run(ACC_SRAM_READ, 8'h93, 8'h03, 1'b0, 8'h04, 0);
    // frame write, trailer placed by sram, full frame read
    load('{8'h11, 8'h22, 8'h33, 8'h4E, 8'h5D, 8'h6C});
    run(ACC_SRAM_WRITE, 8'h01, 8'h06, 1'b0, 8'h02, 8);
    load('{8'h71, 8'h72, 8'h73});
    run(ACC_FB_WRITE, 8'h00, 8'h03, 1'b1, 8'h02, 5);
    run(ACC_FB_READ, 8'h00, 8'h03, 1'b0, 8'h02, 8);
    expect_buf('{8'h03, 8'h71, 8'h72, 8'h73, 8'h4E, 8'h5D, 8'h6C});
    run(ACC_FB_READ, 8'h00, 8'h00, 1'b0, 8'h02, 5);
    expect_buf('{8'h03, 8'h71});
    run(ACC_FB_WRITE, 8'h00, 8'h80, 1'b0, 8'h04, 0);
    run(ACC_FB_WRITE, 8'h00, 8'h7F, 1'b1, 8'h02, 129);
    // prefix follows the status field of the control register
    load('{8'h24});
    run(ACC_REG_WRITE, 8'h04, 8'h00, 1'b0, 8'h02, 2);
    run(ACC_REG_READ, 8'h04, 8'h00, 1'b0, 8'h02, 2);
    expect_buf('{8'h24});
    rd(SW_PREFIX, 8'h01, "prefix_mode");
    close_out();
  end
endmodule : tb_top

`default_nettype wire
